// ---- hw/ccr_pkg.sv ----
// ccr_pkg: constants for the channel configuration and calibration register bank.
// assumes a 32-bit apb with byte addresses; each register index maps to index * 4.
package ccr_pkg;

   // -------------------------------------------------------------------------
   // widths
   // -------------------------------------------------------------------------
   localparam int CCR_REG_W = 16;
   localparam int CCR_APB_DW = 32;
   localparam int CCR_APB_AW = 8;
   localparam int CCR_IDX_W = 6;
   localparam int CCR_TRIM_W = 24;
   localparam int CCR_PHASE_W = 10;
   localparam int CCR_SEL_W = 2;
   localparam int CCR_CNT_W = 8;

   // -------------------------------------------------------------------------
   // register indices (byte address = index * 4)
   // -------------------------------------------------------------------------
   localparam logic [CCR_IDX_W-1:0] CCR_IDX_CHANNEL_SETUP = 6'h0e;
   localparam logic [CCR_IDX_W-1:0] CCR_IDX_OFFSET_TRIM_UPPER = 6'h0f;
   localparam logic [CCR_IDX_W-1:0] CCR_IDX_OFFSET_TRIM_LOWER = 6'h10;
   localparam logic [CCR_IDX_W-1:0] CCR_IDX_GAIN_TRIM_UPPER = 6'h11;
   localparam logic [CCR_IDX_W-1:0] CCR_IDX_GAIN_TRIM_LOWER = 6'h12;
   localparam logic [CCR_IDX_W-1:0] CCR_IDX_BANK_STATUS = 6'h20;
   localparam int CCR_IDX_LSB = 2;

   // -------------------------------------------------------------------------
   // channel_setup fields
   // -------------------------------------------------------------------------
   localparam int CCR_PHASE_MSB = 15;
   localparam int CCR_PHASE_LSB = 6;
   localparam int CCR_DC_OFF_BIT = 2;
   localparam int CCR_SEL_MSB = 1;
   localparam int CCR_SEL_LSB = 0;

   // -------------------------------------------------------------------------
   // split of the 24-bit trims over upper and lower registers
   // -------------------------------------------------------------------------
   localparam int CCR_LOW_FIELD_MSB = 15;
   localparam int CCR_LOW_FIELD_LSB = 8;

   // -------------------------------------------------------------------------
   // bank_status fields
   // -------------------------------------------------------------------------
   localparam int CCR_STAT_ERR_BIT = 0;
   localparam int CCR_STAT_CNT_LSB = 8;
   localparam int CCR_STAT_CNT_MSB = 15;

   // -------------------------------------------------------------------------
   // reset values and writable masks
   // -------------------------------------------------------------------------
   localparam logic [CCR_REG_W-1:0] CCR_RST_CHANNEL_SETUP = 16'h0000;
   localparam logic [CCR_REG_W-1:0] CCR_RST_OFFSET_UPPER = 16'h0000;
   localparam logic [CCR_REG_W-1:0] CCR_RST_OFFSET_LOWER = 16'h0000;
   localparam logic [CCR_REG_W-1:0] CCR_RST_GAIN_UPPER = 16'h8000;
   localparam logic [CCR_REG_W-1:0] CCR_RST_GAIN_LOWER = 16'h0000;
   localparam logic [CCR_REG_W-1:0] CCR_MASK_CHANNEL_SETUP = 16'hffc7;
   localparam logic [CCR_REG_W-1:0] CCR_MASK_FULL = 16'hffff;
   localparam logic [CCR_REG_W-1:0] CCR_MASK_LOWER = 16'hff00;

   // -------------------------------------------------------------------------
   // input selector codes
   // -------------------------------------------------------------------------
   typedef enum logic [CCR_SEL_W-1:0] {
      CCR_SEL_PINS = 2'b00,
      CCR_SEL_SHORTED = 2'b01,
      CCR_SEL_TEST_POS = 2'b10,
      CCR_SEL_TEST_NEG = 2'b11
   } ccr_sel_t;

endpackage

// ---- hw/ccr_field_reg.sv ----
// ccr_field_reg: one 16-bit register with per-byte enables and a writable mask.
// assumes a synchronised active-low reset; bits outside the mask hold their reset value.
module ccr_field_reg #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] RESET_VAL = '0,
   parameter logic [WIDTH-1:0] WR_MASK = '1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // write port
   input wire logic wr_en_i,
   input wire logic [WIDTH/8-1:0] wr_be_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   // contents
   output logic [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] lane_mask;
   logic [WIDTH-1:0] next_q;

   // -------------------------------------------------------------------------
   // byte lanes
   // -------------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH/8; gi++) begin : g_lane
         assign lane_mask[gi*8 +: 8] = {8{wr_be_i[gi]}};
      end
   endgenerate

   // reserved positions ignore the written value and keep reading their reset value
   assign next_q = (q_o & ~(lane_mask & WR_MASK)) | (wr_data_i & lane_mask & WR_MASK);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_o <= RESET_VAL;
      end else if (wr_en_i) begin
         q_o <= next_q;
      end
   end

endmodule // ccr_field_reg

// ---- hw/ccr_regs.sv ----
// ccr_regs: apb slave holding the channel setup and offset/gain trim registers.
// assumes an apb master on ref_clk_i; the converter datapath reads the decoded outputs.
//
// Contract
// - setup bits 15:6 hold signed phase delay
// - setup bit 2 disables this channel's dc filter
// - setup bits 1:0 select the converter input
// - offset upper holds offset bits 23:8
// - offset lower bits 15:8 hold offset 7:0
// - lower trim registers bits 7:0 read zero
// - gain upper holds unsigned gain bits 23:8
// - gain lower bits 15:8 hold gain 7:0
// - gain upper resets to unity 8000h
// - offset upper resets to zero
//
// Implementation choice: register access over APB.
module ccr_regs
   import ccr_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [CCR_APB_AW-1:0] paddr_i,
   input wire logic [CCR_APB_DW-1:0] pwdata_i,
   input wire logic [CCR_APB_DW/8-1:0] pstrb_i,
   output logic pready_o,
   output logic [CCR_APB_DW-1:0] prdata_o,
   output logic pslverr_o,
   // global dc filter control from elsewhere in the converter
   input wire logic global_dc_filter_setting_i,
   // channel configuration to the datapath
   output logic signed [CCR_PHASE_W-1:0] phase_delay_field_o,
   output logic dc_filter_off_bit_o,
   output logic dc_filter_active_o,
   output logic [CCR_SEL_W-1:0] input_selector_o,
   output logic sel_pins_o,
   output logic sel_shorted_o,
   output logic sel_test_pos_o,
   output logic sel_test_neg_o,
   // calibration values to the datapath
   output logic signed [CCR_TRIM_W-1:0] offset_trim_o,
   output logic [CCR_TRIM_W-1:0] gain_trim_o,
   output logic trim_update_o
);

   // -------------------------------------------------------------------------
   // reset release
   // -------------------------------------------------------------------------
   logic rst_meta;
   logic rst_sync_n;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // -------------------------------------------------------------------------
   // apb phase and address decode
   // -------------------------------------------------------------------------
   logic setup_phase;
   logic access_done;
   logic [CCR_IDX_W-1:0] reg_idx;
   logic addr_aligned;
   logic addr_in_range;
   logic hit_setup;
   logic hit_offset_upper;
   logic hit_offset_lower;
   logic hit_gain_upper;
   logic hit_gain_lower;
   logic hit_status;
   logic hit_any;
   logic hit_writable;
   logic [CCR_REG_W/8-1:0] wr_be;

   // the answer is prepared during setup so that pready can come from a flop
   assign setup_phase = psel_i && !penable_i;
   assign access_done = psel_i && penable_i && pready_o;
   assign reg_idx = paddr_i[CCR_IDX_LSB +: CCR_IDX_W];
   assign addr_aligned = (paddr_i[CCR_IDX_LSB-1:0] == 2'h0);
   assign addr_in_range = (paddr_i[CCR_APB_AW-1:CCR_IDX_LSB] == reg_idx);
   assign hit_setup = addr_aligned && (reg_idx == CCR_IDX_CHANNEL_SETUP);
   assign hit_offset_upper = addr_aligned && (reg_idx == CCR_IDX_OFFSET_TRIM_UPPER);
   assign hit_offset_lower = addr_aligned && (reg_idx == CCR_IDX_OFFSET_TRIM_LOWER);
   assign hit_gain_upper = addr_aligned && (reg_idx == CCR_IDX_GAIN_TRIM_UPPER);
   assign hit_gain_lower = addr_aligned && (reg_idx == CCR_IDX_GAIN_TRIM_LOWER);
   assign hit_status = addr_aligned && (reg_idx == CCR_IDX_BANK_STATUS);
   assign hit_writable = hit_setup || hit_offset_upper || hit_offset_lower ||
                         hit_gain_upper || hit_gain_lower;
   assign hit_any = addr_in_range && (hit_writable || hit_status);

   // only the low two byte lanes carry register bits; upper strobes are ignored
   assign wr_be = pstrb_i[CCR_REG_W/8-1:0];

   // -------------------------------------------------------------------------
   // write strobes, taken only at the completing access edge
   // -------------------------------------------------------------------------
   logic wr_ok;
   logic wr_setup;
   logic wr_offset_upper;
   logic wr_offset_lower;
   logic wr_gain_upper;
   logic wr_gain_lower;

   // status is read-only, so a write to it counts as an error and stores nothing
   assign wr_ok = access_done && pwrite_i && addr_in_range;
   assign wr_setup = wr_ok && hit_setup;
   assign wr_offset_upper = wr_ok && hit_offset_upper;
   assign wr_offset_lower = wr_ok && hit_offset_lower;
   assign wr_gain_upper = wr_ok && hit_gain_upper;
   assign wr_gain_lower = wr_ok && hit_gain_lower;

   // -------------------------------------------------------------------------
   // register storage
   // -------------------------------------------------------------------------
   logic [CCR_REG_W-1:0] channel_setup;
   logic [CCR_REG_W-1:0] offset_trim_upper;
   logic [CCR_REG_W-1:0] offset_trim_lower;
   logic [CCR_REG_W-1:0] gain_trim_upper;
   logic [CCR_REG_W-1:0] gain_trim_lower;

   // reserved bits 5:3 are outside the mask and stay zero
   ccr_field_reg #(
      .WIDTH(CCR_REG_W),
      .RESET_VAL(CCR_RST_CHANNEL_SETUP),
      .WR_MASK(CCR_MASK_CHANNEL_SETUP)
   ) u_channel_setup (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_sync_n),
      .wr_en_i(wr_setup),
      .wr_be_i(wr_be),
      .wr_data_i(pwdata_i[CCR_REG_W-1:0]),
      .q_o(channel_setup)
   );

   ccr_field_reg #(
      .WIDTH(CCR_REG_W),
      .RESET_VAL(CCR_RST_OFFSET_UPPER),
      .WR_MASK(CCR_MASK_FULL)
   ) u_offset_trim_upper (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_sync_n),
      .wr_en_i(wr_offset_upper),
      .wr_be_i(wr_be),
      .wr_data_i(pwdata_i[CCR_REG_W-1:0]),
      .q_o(offset_trim_upper)
   );

   ccr_field_reg #(
      .WIDTH(CCR_REG_W),
      .RESET_VAL(CCR_RST_OFFSET_LOWER),
      .WR_MASK(CCR_MASK_LOWER)
   ) u_offset_trim_lower (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_sync_n),
      .wr_en_i(wr_offset_lower),
      .wr_be_i(wr_be),
      .wr_data_i(pwdata_i[CCR_REG_W-1:0]),
      .q_o(offset_trim_lower)
   );

   ccr_field_reg #(
      .WIDTH(CCR_REG_W),
      .RESET_VAL(CCR_RST_GAIN_UPPER),
      .WR_MASK(CCR_MASK_FULL)
   ) u_gain_trim_upper (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_sync_n),
      .wr_en_i(wr_gain_upper),
      .wr_be_i(wr_be),
      .wr_data_i(pwdata_i[CCR_REG_W-1:0]),
      .q_o(gain_trim_upper)
   );

   ccr_field_reg #(
      .WIDTH(CCR_REG_W),
      .RESET_VAL(CCR_RST_GAIN_LOWER),
      .WR_MASK(CCR_MASK_LOWER)
   ) u_gain_trim_lower (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_sync_n),
      .wr_en_i(wr_gain_lower),
      .wr_be_i(wr_be),
      .wr_data_i(pwdata_i[CCR_REG_W-1:0]),
      .q_o(gain_trim_lower)
   );

   // -------------------------------------------------------------------------
   // bank status: last access error and a wrapping write counter
   // -------------------------------------------------------------------------
   logic last_err;
   logic [CCR_CNT_W-1:0] write_count;
   logic access_err;
   logic [CCR_REG_W-1:0] bank_status;

   assign access_err = !hit_any || (pwrite_i && hit_status);

   always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         last_err <= 1'b0;
      end else if (access_done) begin
         last_err <= access_err;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         write_count <= '0;
      end else if (wr_ok && hit_writable) begin
         write_count <= write_count + 8'h01;
      end
   end

   always_comb begin
      bank_status = '0;
      bank_status[CCR_STAT_ERR_BIT] = last_err;
      bank_status[CCR_STAT_CNT_MSB:CCR_STAT_CNT_LSB] = write_count;
   end

   // -------------------------------------------------------------------------
   // read data select
   // -------------------------------------------------------------------------
   logic [CCR_REG_W-1:0] rd_sel;

   // unmapped reads return zero with an error
   assign rd_sel = !addr_in_range ? '0 :
                   hit_setup ? channel_setup :
                   hit_offset_upper ? offset_trim_upper :
                   hit_offset_lower ? offset_trim_lower :
                   hit_gain_upper ? gain_trim_upper :
                   hit_gain_lower ? gain_trim_lower :
                   hit_status ? bank_status : '0;

   // -------------------------------------------------------------------------
   // apb answer: zero wait states, ready in the first access cycle
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pready_o <= 1'b0;
      end else begin
         pready_o <= setup_phase;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         prdata_o <= '0;
      end else if (setup_phase && !pwrite_i) begin
         prdata_o <= {{(CCR_APB_DW-CCR_REG_W){1'b0}}, rd_sel};
      end else if (setup_phase) begin
         prdata_o <= '0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pslverr_o <= 1'b0;
      end else begin
         pslverr_o <= setup_phase && access_err;
      end
   end

   // -------------------------------------------------------------------------
   // decoded configuration
   // -------------------------------------------------------------------------
   logic [CCR_SEL_W-1:0] sel_field;
   logic dc_off;
   logic [CCR_TRIM_W-1:0] next_offset;
   logic [CCR_TRIM_W-1:0] next_gain;

   assign sel_field = channel_setup[CCR_SEL_MSB:CCR_SEL_LSB];
   assign dc_off = channel_setup[CCR_DC_OFF_BIT];
   // upper register carries bits 23:8, the lower register's top byte bits 7:0
   assign next_offset = {offset_trim_upper,
                         offset_trim_lower[CCR_LOW_FIELD_MSB:CCR_LOW_FIELD_LSB]};
   assign next_gain = {gain_trim_upper,
                       gain_trim_lower[CCR_LOW_FIELD_MSB:CCR_LOW_FIELD_LSB]};

   always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         phase_delay_field_o <= '0;
         input_selector_o <= CCR_SEL_PINS;
         dc_filter_off_bit_o <= 1'b0;
      end else begin
         phase_delay_field_o <= channel_setup[CCR_PHASE_MSB:CCR_PHASE_LSB];
         input_selector_o <= sel_field;
         dc_filter_off_bit_o <= dc_off;
      end
   end

   // a set off bit overrides the global filter setting for this channel only
   always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         dc_filter_active_o <= 1'b0;
      end else begin
         dc_filter_active_o <= global_dc_filter_setting_i && !dc_off;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sel_pins_o <= 1'b1;
         sel_shorted_o <= 1'b0;
         sel_test_pos_o <= 1'b0;
         sel_test_neg_o <= 1'b0;
      end else begin
         sel_pins_o <= (sel_field == CCR_SEL_PINS);
         sel_shorted_o <= (sel_field == CCR_SEL_SHORTED);
         sel_test_pos_o <= (sel_field == CCR_SEL_TEST_POS);
         sel_test_neg_o <= (sel_field == CCR_SEL_TEST_NEG);
      end
   end

   // -------------------------------------------------------------------------
   // calibration outputs
   // -------------------------------------------------------------------------
   // values follow each half as soon as it is written; software that needs a
   // glitch-free change writes the lower half while the datapath is idle
   always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         offset_trim_o <= '0;
         gain_trim_o <= {CCR_RST_GAIN_UPPER,
                         CCR_RST_GAIN_LOWER[CCR_LOW_FIELD_MSB:CCR_LOW_FIELD_LSB]};
      end else begin
         offset_trim_o <= next_offset;
         gain_trim_o <= next_gain;
      end
   end

   // pulse comes one cycle before the new trim first shows on offset_trim_o and gain_trim_o
   always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         trim_update_o <= 1'b0;
      end else begin
         trim_update_o <= wr_ok && hit_writable;
      end
   end

endmodule // ccr_regs

// ---- tb/ccr_regs_asserts.sv ----
// ccr_regs_asserts: concurrent checks on the ports of ccr_regs.
// assumes the apb master leaves three edges after reset release before its first setup.
module ccr_regs_asserts
   import ccr_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [CCR_APB_AW-1:0] paddr_i,
   input wire logic [CCR_APB_DW-1:0] pwdata_i,
   input wire logic [CCR_APB_DW/8-1:0] pstrb_i,
   input wire logic pready_o,
   input wire logic [CCR_APB_DW-1:0] prdata_o,
   input wire logic pslverr_o,
   input wire logic global_dc_filter_setting_i,
   input wire logic signed [CCR_PHASE_W-1:0] phase_delay_field_o,
   input wire logic dc_filter_off_bit_o,
   input wire logic dc_filter_active_o,
   input wire logic [CCR_SEL_W-1:0] input_selector_o,
   input wire logic sel_pins_o,
   input wire logic sel_shorted_o,
   input wire logic sel_test_pos_o,
   input wire logic sel_test_neg_o,
   input wire logic signed [CCR_TRIM_W-1:0] offset_trim_o,
   input wire logic [CCR_TRIM_W-1:0] gain_trim_o,
   input wire logic trim_update_o
);
   localparam logic [7:0] A_SET = {CCR_IDX_CHANNEL_SETUP, 2'b00};
   localparam logic [7:0] A_OU = {CCR_IDX_OFFSET_TRIM_UPPER, 2'b00};
   localparam logic [7:0] A_OL = {CCR_IDX_OFFSET_TRIM_LOWER, 2'b00};
   localparam logic [7:0] A_GU = {CCR_IDX_GAIN_TRIM_UPPER, 2'b00};
   localparam logic [7:0] A_GL = {CCR_IDX_GAIN_TRIM_LOWER, 2'b00};
   // the internal reset copy lags the pin, so derived flops are judged only once settled
   logic [2:0] up_cnt;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) up_cnt <= 3'h0;
      else if (up_cnt != 3'h4) up_cnt <= up_cnt + 3'h1;
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence wr_to(a);
      psel_i && !penable_i && pwrite_i && paddr_i == a && pstrb_i[1:0] == 2'b11
      ##1 psel_i && penable_i && pready_o;
   endsequence
   ready_next_a: assert property (psel_i && !penable_i |=> pready_o)
      else $error("pready missing after setup");
   ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("pready held");
   rdata_high_a: assert property (pready_o |-> prdata_o[31:16] == 16'h0000)
      else $error("prdata upper half not zero");
   misalign_err_a: assert property (pready_o && paddr_i[1:0] != 2'b00 |-> pslverr_o
      && prdata_o == '0) else $error("misaligned access not refused");
   lower_zero_a: assert property (pready_o && !pwrite_i &&
      (paddr_i == A_OL || paddr_i == A_GL) |-> prdata_o[7:0] == 8'h00)
      else $error("reserved byte reads non-zero");
   phase_lands_a: assert property (wr_to(A_SET) |-> ##2
      phase_delay_field_o == $past(pwdata_i[15:6], 2)) else $error("phase delay wrong");
   setup_low_a: assert property (wr_to(A_SET) |-> ##2
      {dc_filter_off_bit_o, input_selector_o} == $past(pwdata_i[2:0], 2))
      else $error("filter bit or selector wrong");
   sel_decode_a: assert property (up_cnt == 3'h4 |->
      {sel_pins_o, sel_shorted_o, sel_test_pos_o, sel_test_neg_o} == (4'b1000 >> input_selector_o))
      else $error("selector decode wrong");
   dc_active_a: assert property (up_cnt == 3'h4 |-> dc_filter_active_o ==
      ($past(global_dc_filter_setting_i) && !dc_filter_off_bit_o)) else $error("dc filter wrong");
   off_high_a: assert property (wr_to(A_OU) |-> ##2
      offset_trim_o[23:8] == $past(pwdata_i[15:0], 2)) else $error("offset upper wrong");
   off_low_a: assert property (wr_to(A_OL) |-> ##2
      offset_trim_o[7:0] == $past(pwdata_i[15:8], 2)) else $error("offset lower wrong");
   gain_high_a: assert property (wr_to(A_GU) |-> ##2
      gain_trim_o[23:8] == $past(pwdata_i[15:0], 2)) else $error("gain upper wrong");
   gain_low_a: assert property (wr_to(A_GL) |-> ##2
      gain_trim_o[7:0] == $past(pwdata_i[15:8], 2)) else $error("gain lower wrong");
   // an accepted write completes without error, and only such a write may pulse the update
   update_pulse_a: assert property (trim_update_o == ($past(psel_i) && $past(penable_i) &&
      $past(pready_o) && $past(pwrite_i) && !$past(pslverr_o))) else $error("update pulse wrong");
endmodule // ccr_regs_asserts

bind ccr_regs ccr_regs_asserts u_chk (.*);

// ---- tb/ccr_regs_tb.sv ----
// ccr_regs_tb: self-checking bench for the channel setup and trim register bank.
// assumes zero-wait apb answers; read results are queued and matched by a monitor.
module ccr_regs_tb
   import ccr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_count++; \
   $display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); end end
   localparam logic [7:0] A_SET = {CCR_IDX_CHANNEL_SETUP, 2'b00};
   localparam logic [7:0] A_OU = {CCR_IDX_OFFSET_TRIM_UPPER, 2'b00};
   localparam logic [7:0] A_OL = {CCR_IDX_OFFSET_TRIM_LOWER, 2'b00};
   localparam logic [7:0] A_GU = {CCR_IDX_GAIN_TRIM_UPPER, 2'b00};
   localparam logic [7:0] A_GL = {CCR_IDX_GAIN_TRIM_LOWER, 2'b00};
   logic ref_clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [7:0] paddr_i = '0;
   logic [31:0] pwdata_i = '0;
   logic [3:0] pstrb_i = '0;
   logic global_dc_filter_setting_i = 0;
   logic pready_o, pslverr_o, dc_filter_off_bit_o, dc_filter_active_o, trim_update_o;
   logic sel_pins_o, sel_shorted_o, sel_test_pos_o, sel_test_neg_o;
   logic [31:0] prdata_o;
   logic signed [9:0] phase_delay_field_o;
   logic [1:0] input_selector_o;
   logic signed [23:0] offset_trim_o;
   logic [23:0] gain_trim_o;
   int err_count = 0, compares = 0;
   logic [32:0] notes [$];
   logic [32:0] note;
   logic [31:0] seed = 32'h00000013;
   logic [31:0] v [5];
   logic [7:0] addr [5] = '{A_SET, A_OU, A_OL, A_GU, A_GL};
   logic [15:0] mask [5] = '{CCR_MASK_CHANNEL_SETUP, CCR_MASK_FULL, CCR_MASK_LOWER,
      CCR_MASK_FULL, CCR_MASK_LOWER};

   always #2 ref_clk_i = ~ref_clk_i;

   ccr_regs uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .pstrb_i(pstrb_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
      .global_dc_filter_setting_i(global_dc_filter_setting_i),
      .phase_delay_field_o(phase_delay_field_o), .dc_filter_off_bit_o(dc_filter_off_bit_o),
      .dc_filter_active_o(dc_filter_active_o), .input_selector_o(input_selector_o),
      .sel_pins_o(sel_pins_o), .sel_shorted_o(sel_shorted_o), .sel_test_pos_o(sel_test_pos_o),
      .sel_test_neg_o(sel_test_neg_o), .offset_trim_o(offset_trim_o),
      .gain_trim_o(gain_trim_o), .trim_update_o(trim_update_o));

   // -------------------------------------------------------------------------
   // apb master and result monitor
   // -------------------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] st, input logic err, input logic [15:0] exp);
      int n;
      // writes and refused accesses return zero data
      notes.push_back({err, (wr || err) ? 32'h0 : {16'h0, exp}});
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      pstrb_i <= {d[31:30], st};
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 16);
      if (n >= 16) begin
         err_count++;
         $display("ERROR t=%0t got %h exp %h", $time, 1'b0, 1'b1);
      end
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 2'b11, 1'b0, 16'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      seed = xs(seed);
      apb(1'b0, a, seed, 2'b11, 1'b0, exp);
   endtask

   always @(posedge ref_clk_i) begin
      if (psel_i && penable_i && pready_o === 1'b1) begin
         note = (notes.size() != 0) ? notes.pop_front() : 33'h1ffffffff;
         `CHK({pslverr_o, prdata_o}, note)
      end
   end

   task print_verdict;
      if (notes.size() != 0) err_count++;
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      #50000;
      err_count++;
      print_verdict();
   end

   // -------------------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------------------
   initial begin
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      rd(A_SET, 16'h0000);
      rd(A_OU, 16'h0000);
      rd(A_OL, 16'h0000);
      rd(A_GU, 16'h8000);
      rd(A_GL, 16'h0000);
      `CHK(gain_trim_o, 24'h800000)
      `CHK(offset_trim_o, 24'h000000)
      for (int i = 0; i < 8; i++) begin
         for (int j = 0; j < 5; j++) begin
            seed = xs(seed);
            v[j] = seed;
            wr(addr[j], seed);
         end
         for (int j = 0; j < 5; j++) rd(addr[j], v[j][15:0] & mask[j]);
         `CHK(phase_delay_field_o, v[0][15:6])
         `CHK({dc_filter_off_bit_o, input_selector_o}, v[0][2:0])
         `CHK(offset_trim_o, {v[1][15:0], v[2][15:8]})
         `CHK(gain_trim_o, {v[3][15:0], v[4][15:8]})
      end
      // every selector code with the filter bit both ways under a random global setting
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         global_dc_filter_setting_i <= seed[0];
         wr(A_SET, {seed[31:3], i[2:0]});
         repeat (3) @(posedge ref_clk_i);
         `CHK({sel_pins_o, sel_shorted_o, sel_test_pos_o, sel_test_neg_o},
            4'b1000 >> i[1:0])
         `CHK(dc_filter_active_o, seed[0] & ~i[2])
      end
      wr(A_GU, 32'h00000000);
      apb(1'b1, A_GU, 32'h0000abcd, 2'b10, 1'b0, 16'h0);
      rd(A_GU, 16'hab00);
      apb(1'b0, 8'h4c, 32'h0, 2'b11, 1'b1, 16'h0);
      apb(1'b1, A_GU | 8'h01, 32'hffff, 2'b11, 1'b1, 16'h0);
      apb(1'b1, {CCR_IDX_BANK_STATUS, 2'b00}, 32'hffff, 2'b11, 1'b1, 16'h0);
      // status: last access refused, 50 accepted writes so far (refused ones not counted)
      rd({CCR_IDX_BANK_STATUS, 2'b00}, 16'h3201);
      rd(A_GU, 16'hab00);
      // a second reset in mid-run must restore unity gain and zero offset
      rst_n_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      rd(A_GU, 16'h8000);
      rd(A_OU, 16'h0000);
      repeat (2) @(posedge ref_clk_i);
      print_verdict();
   end
endmodule // ccr_regs_tb
